// ---- bench/tape_adapter_command_status_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of command taking and status reporting
module tape_adapter_command_status_checker
    import tape_adapter_pkg::*;
#(
    parameter int N_UNITS     = UNITS,
    parameter int HOST_LIMIT  = HOST_LIMIT_CYC,
    parameter int ANSWER_WAIT = UNIT_ANS_CYC
) (
    input wire logic                mclk,
    input wire logic                reset,
    input wire logic [WORD_W-1:0]   cmd_word,
    input wire logic                cmd_strobe,
    input wire logic [WORD_W-1:0]   status_word,
    input wire logic                status_irq,
    input wire logic                status_read,
    input wire logic                adapter_busy,
    input wire logic [N_UNITS-1:0]  unit_select,
    input wire logic [OPCODE_W-1:0] unit_opcode,
    input wire logic                unit_start,
    input wire logic                xfer_out_en,
    input wire logic                xfer_in_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Strobe while idle is a taken command
    wire logic accept = cmd_strobe && !adapter_busy;

    a_accept_busy: assert property (accept |=> adapter_busy [*3])
        else $error("busy missing after accept");
    // Fields reach the unit pins one edge after the command latch
    a_accept_fields: assert property (accept |=> ##1 unit_select == $past(cmd_word[21:15], 2)
        && unit_opcode == $past(cmd_word[14:11], 2)) else $error("unit fields wrong");
    a_plain_answer: assert property (accept && cmd_word[5:4] == 2'h0
        |-> ##[4:24] $rose(status_irq)) else $error("no status report");
    a_irq_holds: assert property (status_irq && !status_read |=> status_irq)
        else $error("interrupt dropped early");
    // A new report in the same cycle wins over the read
    a_read_drops: assert property (status_irq && status_read && !adapter_busy |=> !status_irq)
        else $error("interrupt not withdrawn");
    a_abn_summary: assert property (status_irq |-> status_word[0] == |status_word[6:3])
        else $error("abnormal summary wrong");
    a_term_copy: assert property (status_irq |-> status_word[2] == |status_word[14:11])
        else $error("terminal flag wrong");
    a_spare_zero: assert property (status_irq |-> status_word[10:7] == 4'h0
        && status_word[29:15] == 15'h0) else $error("spare bits set");
    a_skip_start: assert property ($rose(status_irq) && (status_word[1] || status_word[2])
        |-> !$past(unit_start)) else $error("refused command started");
    a_start_busy: assert property (unit_start || xfer_out_en || xfer_in_en
        |-> adapter_busy) else $error("activity while idle");
endmodule
bind tape_adapter_command_status tape_adapter_command_status_checker #(.N_UNITS(N_UNITS),
    .HOST_LIMIT(HOST_LIMIT), .ANSWER_WAIT(ANSWER_WAIT)) checker_i (.mclk, .reset, .cmd_word,
    .cmd_strobe, .status_word, .status_irq, .status_read, .adapter_busy, .unit_select,
    .unit_opcode, .unit_start, .xfer_out_en, .xfer_in_en);
`default_nettype wire

// ---- bench/tape_adapter_command_status_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module tape_adapter_command_status_test;
    import tape_adapter_pkg::*;
    typedef struct packed {
        logic [29:0] cmd;
        logic [6:0]  on, rdy, err;
        logic [27:0] term;
        logic        bad;
        logic [29:0] exp;
    } row_t;
    logic mclk, reset, cmd_strobe, status_read, status_irq, adapter_busy, unit_start;
    logic host_data_req, host_data_ack, xfer_out_en, xfer_in_en, char_valid, xfer_done, bad;
    logic [29:0] cmd_word, status_word;
    logic [6:0]  on, rdy, err, sel, u_on, u_rdy, u_err, char_bits;
    logic [27:0] term, u_term;
    logic [3:0]  opc;
    int fail_count = 0;
    int check_count = 0;
    // Row: command, online, ready, error, terminal lines, bad parity, report
    row_t rows [12] = '{
        '{30'h0009800, 7'h7F, 7'h7F, 7'h00, 28'h0F00000, 1'b0, 30'h0000000},
        '{30'h0206000, 7'h7F, 7'h7F, 7'h00, 28'h0, 1'b0, 30'h0000000},
        '{30'h0000800, 7'h7F, 7'h7F, 7'h00, 28'h0, 1'b0, 30'h0000011},
        '{30'h0019000, 7'h7F, 7'h7F, 7'h00, 28'h0, 1'b0, 30'h0000011},
        '{30'h0022800, 7'h7B, 7'h7F, 7'h00, 28'h0, 1'b0, 30'h0000011},
        '{30'h0013800, 7'h7F, 7'h7D, 7'h00, 28'h0, 1'b0, 30'h0000002},
        '{30'h0008000, 7'h7F, 7'h7F, 7'h01, 28'h0, 1'b0, 30'h0000009},
        '{30'h0044800, 7'h7F, 7'h7F, 7'h00, 28'h000C000, 1'b0, 30'h0006004},
        '{30'h0044880, 7'h7F, 7'h7F, 7'h00, 28'h000C000, 1'b0, 30'h0000000},
        '{30'h0008810, 7'h7F, 7'h7F, 7'h00, 28'h0, 1'b0, 30'h0000000},
        '{30'h000C020, 7'h7F, 7'h7F, 7'h00, 28'h0, 1'b0, 30'h0000000},
        '{30'h000C020, 7'h7F, 7'h7F, 7'h00, 28'h0, 1'b1, 30'h0000021}};

    tape_adapter_command_status #(.HOST_LIMIT(20)) tape_adapter_command_status_i (.mclk, .reset,
        .cmd_word, .cmd_strobe, .status_word, .status_irq, .status_read, .adapter_busy,
        .unit_online(u_on), .unit_ready(u_rdy), .unit_equip_err(u_err), .unit_term(u_term),
        .unit_select(sel), .unit_opcode(opc), .unit_start, .xfer_out_en, .xfer_in_en,
        .char_valid, .char_bits, .host_data_req, .host_data_ack, .xfer_done);
    tape_units_model tape_units_model_i (.mclk, .cfg_online(on), .cfg_ready(rdy), .cfg_err(err),
        .cfg_term(term), .cfg_bad_par(bad), .unit_select(sel), .unit_start, .xfer_in_en,
        .xfer_out_en, .unit_online(u_on), .unit_ready(u_rdy), .unit_equip_err(u_err),
        .unit_term(u_term), .char_valid, .char_bits, .xfer_done);

    task automatic chk(input string nm, input logic [29:0] e, input logic [29:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One command, wait for its report, then read it out
    task automatic run_cmd(input logic [29:0] c, input logic [29:0] e);
        int n;
        n = 0;
        cmd_word = c;
        cmd_strobe = 1'b1;
        @(negedge mclk);
        cmd_strobe = 1'b0;
        @(negedge mclk);
        chk("unit_select", {23'h0, c[21:15]}, {23'h0, sel});
        chk("unit_opcode", {26'h0, c[14:11]}, {26'h0, opc});
        while (status_irq !== 1'b1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        chk("status_word", e, status_word);
        status_read = 1'b1;
        @(negedge mclk);
        status_read = 1'b0;
        @(negedge mclk);
        chk("status_irq", 30'h0, {29'h0, status_irq});
        repeat (8) @(negedge mclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        wrap_up();
    end

    initial begin
        {reset, cmd_strobe, status_read, host_data_req, host_data_ack, bad} = 6'h20;
        {cmd_word, on, rdy, err, term} = {30'h0, 7'h7F, 7'h7F, 7'h00, 28'h0};
        repeat (10) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        foreach (rows[i]) begin
            {on, rdy, err, term, bad} = {rows[i].on, rows[i].rdy, rows[i].err, rows[i].term, rows[i].bad};
            repeat (4) @(negedge mclk);
            run_cmd(rows[i].cmd, rows[i].exp);
        end
        {term, bad} = 29'h0;
        for (int op = 0; op < 13; op++)
            run_cmd(30'h0100000 | (30'(op) << 11), 30'h0);
        // Host stalls a data request past the limit
        host_data_req = 1'b1;
        run_cmd(30'h0008810, 30'h0000041);
        host_data_req = 1'b0;
        // Second strobe while busy must be ignored
        cmd_word = 30'h0009800;
        cmd_strobe = 1'b1;
        @(negedge mclk);
        cmd_strobe = 1'b0;
        @(negedge mclk);
        {cmd_word, cmd_strobe} = {30'h0000800, 1'b1};
        repeat (2) @(negedge mclk);
        cmd_strobe = 1'b0;
        @(negedge mclk);
        // First report stands; the refused word would have given no-response
        chk("status_irq", 30'h1, {29'h0, status_irq});
        chk("status_word", 30'h0, status_word);
        status_read = 1'b1;
        @(negedge mclk);
        status_read = 1'b0;
        repeat (30) @(negedge mclk);
        chk("status_irq", 30'h0, {29'h0, status_irq});
        chk("status_word", 30'h0, status_word);
        run_cmd(30'h0009800, 30'h0);
        chk("status_irq", 30'h0, {29'h0, status_irq});
        // Reset in mid command clears the outputs
        cmd_strobe = 1'b1;
        @(negedge mclk);
        {cmd_strobe, reset} = 2'h1;
        repeat (10) @(negedge mclk);
        chk("adapter_busy", 30'h0, {29'h0, adapter_busy});
        chk("status_word", 30'h0, status_word);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        run_cmd(30'h0009800, 30'h0);
        wrap_up();
    end
endmodule
`default_nettype wire

// ---- bench/tape_units_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Seven tape units and the serial section, set up by the bench
module tape_units_model
    import tape_adapter_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic [UNITS-1:0]        cfg_online,
    input  wire logic [UNITS-1:0]        cfg_ready,
    input  wire logic [UNITS-1:0]        cfg_err,
    input  wire logic [UNITS*TERM_W-1:0] cfg_term,
    input  wire logic                    cfg_bad_par,
    input  wire logic [UNITS-1:0]        unit_select,
    input  wire logic                    unit_start,
    input  wire logic                    xfer_in_en,
    input  wire logic                    xfer_out_en,
    output logic [UNITS-1:0]             unit_online,
    output logic [UNITS-1:0]             unit_ready,
    output logic [UNITS-1:0]             unit_equip_err,
    output logic [UNITS*TERM_W-1:0]      unit_term,
    output logic                         char_valid,
    output logic [6:0]                   char_bits,
    output logic                         xfer_done
);
    logic [3:0]       move_reg = 4'h0;
    logic [UNITS-1:0] moving_reg = '0;
    logic [5:0]       tick_reg = 6'h0;

    // A started unit is busy moving tape for a while
    always_ff @(posedge mclk) begin
        if (unit_start) begin
            move_reg <= 4'h3;
            moving_reg <= unit_select;
        end else if (move_reg != 4'h0) begin
            move_reg <= move_reg - 4'h1;
        end else begin
            moving_reg <= '0;
        end
        tick_reg <= (xfer_in_en | xfer_out_en) ? tick_reg + 6'h1 : 6'h0;
    end

    // Pins, odd parity on 2A unless bad parity is asked for
    assign unit_online = cfg_online;
    assign unit_ready = cfg_ready & ~moving_reg;
    assign unit_equip_err = cfg_err;
    assign unit_term = cfg_term;
    assign char_valid = xfer_in_en && tick_reg[2:1] == 2'h1;
    assign char_bits = {cfg_bad_par, 6'h2A};
    assign xfer_done = tick_reg == 6'h2F;
endmodule
`default_nettype wire

// ---- rtl/tape_adapter_command_status.sv ----
`timescale 1ns/1ps
`default_nettype none
module tape_adapter_command_status
    import tape_adapter_pkg::*;
#(
    parameter int N_UNITS     = UNITS,
    parameter int HOST_LIMIT  = HOST_LIMIT_CYC,
    parameter int ANSWER_WAIT = UNIT_ANS_CYC
) (
    input  wire logic                      mclk,
    input  wire logic                      reset,
    // Host output channel: command word
    input  wire logic [WORD_W-1:0]         cmd_word,
    input  wire logic                      cmd_strobe,
    // Host input channel: status word and interrupt
    output logic [WORD_W-1:0]              status_word,
    output logic                           status_irq,
    input  wire logic                      status_read,
    output logic                           adapter_busy,
    // Tape unit side
    input  wire logic [N_UNITS-1:0]        unit_online,
    input  wire logic [N_UNITS-1:0]        unit_ready,
    input  wire logic [N_UNITS-1:0]        unit_equip_err,
    input  wire logic [N_UNITS*TERM_W-1:0] unit_term,
    output logic [N_UNITS-1:0]             unit_select,
    output logic [OPCODE_W-1:0]            unit_opcode,
    output logic                           unit_start,
    // Data path enables to the serial section; events from it and the host
    output logic                           xfer_out_en,
    output logic                           xfer_in_en,
    input  wire logic                      char_valid,
    input  wire logic [6:0]                char_bits,
    input  wire logic                      host_data_req,
    input  wire logic                      host_data_ack,
    input  wire logic                      xfer_done
);
    typedef enum logic [2:0] {IDLE, INTERROGATE, EVALUATE, TRANSFER, REPORT} state_t;

    state_t              state_reg, state_next;
    command_t            cmd_reg;
    command_t            cmd_in;
    logic [CNT_W-1:0]    wait_reg;
    logic [CNT_W-1:0]    host_cnt_reg;
    logic                pending_reg;
    logic                par_err_reg, time_err_reg;
    logic                nrdy_reg;
    logic [TERM_W-1:0]   term_snap_reg;
    logic [WORD_W-1:0]   status_next;

    // Input synchronisers for unit pins (two flops before any logic)
    logic [N_UNITS-1:0]        on_s1, on_s2, rdy_s1, rdy_s2, err_s1, err_s2;
    logic [N_UNITS*TERM_W-1:0] term_s1, term_s2;
    logic [6:0]                chr_s1, chr_s2;
    logic                      cv_s1, cv_s2;

    always_ff @(posedge mclk) begin
        on_s1   <= unit_online;
        on_s2   <= on_s1;
        rdy_s1  <= unit_ready;
        rdy_s2  <= rdy_s1;
        err_s1  <= unit_equip_err;
        err_s2  <= err_s1;
        term_s1 <= unit_term;
        term_s2 <= term_s1;
        chr_s1  <= char_bits;
        chr_s2  <= chr_s1;
        cv_s1   <= char_valid;
        cv_s2   <= cv_s1;
    end

    // Field decode of the incoming command word
    assign cmd_in.unit_sel = cmd_word[CMD_UNIT_LSB +: UNITS];
    assign cmd_in.opcode   = cmd_word[CMD_OP_LSB +: OPCODE_W];
    assign cmd_in.lockout  = cmd_word[CMD_LOCK_BIT];
    assign cmd_in.xfer_in  = cmd_word[CMD_IN_BIT];
    assign cmd_in.xfer_out = cmd_word[CMD_OUT_BIT];

    wire        answers;
    unit_cond_t cond;

    unit_select_check #(
        .N (N_UNITS)
    ) u_sel (
        .unit_sel       (cmd_reg.unit_sel),
        .unit_online    (on_s2),
        .unit_ready     (rdy_s2),
        .unit_equip_err (err_s2),
        .unit_term      (term_s2),
        .answers        (answers),
        .cond           (cond)
    );

    // A command is taken only while idle; others are dropped
    wire accept     = cmd_strobe && (state_reg == IDLE);
    wire wait_done  = (wait_reg == CNT_W'(ANSWER_WAIT));
    wire term_hit   = !cmd_reg.lockout && (term_snap_reg != '0);
    wire blocked    = !cond.ready || cond.equip_err || term_hit;
    wire any_xfer   = cmd_reg.xfer_out || cmd_reg.xfer_in;
    wire host_late  = (host_cnt_reg >= CNT_W'(HOST_LIMIT - 1));
    // Odd parity: an even count of ones across seven bits is a fault
    wire parity_bad = cv_s2 && !(^chr_s2);

    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IDLE:        if (accept) state_next = INTERROGATE;
            INTERROGATE: if (answers) state_next = EVALUATE;
                         else if (wait_done) state_next = REPORT;
            EVALUATE:    if (blocked || !any_xfer) state_next = REPORT;
                         else state_next = TRANSFER;
            TRANSFER:    if (xfer_done || host_late) state_next = REPORT;
            REPORT:      state_next = IDLE;
            default:     state_next = IDLE;
        endcase
    end

    // Status word assembly; unassigned positions stay zero
    logic nresp, nrdy, eqerr, term_rep;
    assign nresp    = !answers;
    assign eqerr    = answers && cond.equip_err;
    // Not-ready is judged before the start; a started unit goes busy on its own
    assign nrdy     = answers && nrdy_reg;
    assign term_rep = answers && term_hit;
    always_comb begin
        status_next = '0;
        status_next[ST_EQERR_BIT]  = eqerr;
        status_next[ST_NORESP_BIT] = nresp;
        status_next[ST_PAR_BIT]    = par_err_reg;
        status_next[ST_TIME_BIT]   = time_err_reg;
        status_next[ST_ABN_BIT]    = eqerr | nresp | par_err_reg | time_err_reg;
        status_next[ST_NRDY_BIT]   = nrdy;
        status_next[ST_TERM_BIT]   = term_rep;
        // Line W lands in bit 14 down to line Z in bit 11
        for (int k = 0; k < TERM_W; k++) begin
            status_next[ST_TLINE_LSB + k] = term_rep & term_snap_reg[k];
        end
    end

    // State and command latch
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= IDLE;
            cmd_reg   <= '0;
        end else begin
            state_reg <= state_next;
            if (accept) cmd_reg <= cmd_in;
        end
    end

    // Terminal lines are frozen at the answer so later changes are not reported
    always_ff @(posedge mclk) begin
        if (reset) begin
            term_snap_reg <= '0;
        end else if (state_reg == INTERROGATE && answers) begin
            term_snap_reg <= cond.term_lines;
        end
    end

    // Interrogation timeout counter
    always_ff @(posedge mclk) begin
        if (reset || state_reg != INTERROGATE) begin
            wait_reg <= '0;
        end else if (!wait_done) begin
            wait_reg <= wait_reg + 1'b1;
        end
    end

    // Host response timer restarts on each acknowledge
    always_ff @(posedge mclk) begin
        if (reset || state_reg != TRANSFER || host_data_ack || !host_data_req) begin
            host_cnt_reg <= '0;
        end else begin
            host_cnt_reg <= host_cnt_reg + 1'b1;
        end
    end

    // Error flags live for one command; cleared on acceptance
    always_ff @(posedge mclk) begin
        if (reset || accept) begin
            par_err_reg  <= 1'b0;
            time_err_reg <= 1'b0;
            nrdy_reg     <= 1'b0;
        end else if (state_reg == EVALUATE) begin
            nrdy_reg <= !cond.ready;
        end else if (state_reg == TRANSFER) begin
            if (cmd_reg.xfer_in && parity_bad) par_err_reg <= 1'b1;
            if (host_late) time_err_reg <= 1'b1;
        end
    end

    // Unit control outputs; the start pulse is withheld when blocked
    always_ff @(posedge mclk) begin
        if (reset) begin
            unit_select <= '0;
            unit_opcode <= '0;
            unit_start  <= 1'b0;
            xfer_out_en <= 1'b0;
            xfer_in_en  <= 1'b0;
        end else begin
            unit_select <= (state_reg == IDLE) ? '0 : cmd_reg.unit_sel;
            unit_opcode <= cmd_reg.opcode;
            unit_start  <= (state_reg == EVALUATE) && !blocked;
            xfer_out_en <= (state_next == TRANSFER) && cmd_reg.xfer_out;
            xfer_in_en  <= (state_next == TRANSFER) && cmd_reg.xfer_in;
        end
    end

    // Interrupt: raised once per command, dropped by the status read
    always_ff @(posedge mclk) begin
        if (reset) begin
            status_irq  <= 1'b0;
            status_word <= '0;
            pending_reg <= 1'b0;
        end else begin
            if (state_reg == REPORT) begin
                status_irq  <= 1'b1;
                status_word <= status_next;
                pending_reg <= 1'b1;
            end else if (status_read && pending_reg) begin
                status_irq  <= 1'b0;
                pending_reg <= 1'b0;
            end
        end
    end

    // Busy from acceptance until the report is issued
    always_ff @(posedge mclk) begin
        if (reset) begin
            adapter_busy <= 1'b0;
        end else begin
            adapter_busy <= (state_next != IDLE);
        end
    end
endmodule
`default_nettype wire

// ---- rtl/tape_adapter_pkg.sv ----
package tape_adapter_pkg;

    localparam int WORD_W       = 30;
    localparam int UNITS        = 7;
    localparam int OPCODE_W     = 4;
    localparam int TERM_W       = 4;
    localparam int BLOCK_WORDS  = 24;

    // Command word field positions
    localparam int CMD_OUT_BIT   = 4;
    localparam int CMD_IN_BIT    = 5;
    localparam int CMD_LOCK_BIT  = 7;
    localparam int CMD_OP_LSB    = 11;
    localparam int CMD_UNIT_LSB  = 15;

    // Status word field positions
    localparam int ST_ABN_BIT    = 0;
    localparam int ST_NRDY_BIT   = 1;
    localparam int ST_TERM_BIT   = 2;
    localparam int ST_EQERR_BIT  = 3;
    localparam int ST_NORESP_BIT = 4;
    localparam int ST_PAR_BIT    = 5;
    localparam int ST_TIME_BIT   = 6;
    localparam int ST_TLINE_LSB  = 11;

    // Host response limit and derived cycle count at 40 MHz
    localparam int CLK_HZ        = 40_000_000;
    localparam int HOST_LIMIT_US = 210;
    localparam int HOST_LIMIT_CYC = (HOST_LIMIT_US * (CLK_HZ / 1_000_000));

    // Cycles allowed for the selected unit to answer its interrogation
    localparam int UNIT_ANS_CYC  = 16;
    localparam int CNT_W         = 16;

    // Decoded command word
    typedef struct packed {
        logic [UNITS-1:0]    unit_sel;
        logic [OPCODE_W-1:0] opcode;
        logic                lockout;
        logic                xfer_in;
        logic                xfer_out;
    } command_t;

    // Unit-side condition lines
    typedef struct packed {
        logic              ready;
        logic              equip_err;
        logic [TERM_W-1:0] term_lines;
    } unit_cond_t;

endpackage

// ---- rtl/unit_select_check.sv ----
`timescale 1ns/1ps
`default_nettype none
// Checks the one-hot unit field and picks that unit's conditions
module unit_select_check
    import tape_adapter_pkg::*;
#(
    parameter int N = UNITS
) (
    input  wire logic [N-1:0]       unit_sel,
    input  wire logic [N-1:0]       unit_online,
    input  wire logic [N-1:0]       unit_ready,
    input  wire logic [N-1:0]       unit_equip_err,
    input  wire logic [N*TERM_W-1:0] unit_term,
    output logic                    answers,
    output unit_cond_t              cond
);
    logic [N-1:0]      hit;
    logic [TERM_W-1:0] term_or [N:0];
    logic              one_hot;

    // Only a single set bit counts as a valid selection
    assign one_hot = (unit_sel != '0) && ((unit_sel & (unit_sel - 1'b1)) == '0);
    assign hit     = unit_sel & unit_online;
    assign answers = one_hot && (hit != '0);

    // OR-mux the selected unit's lines
    assign term_or[0] = '0;
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_mux
            assign term_or[i+1] = term_or[i] | (hit[i] ? unit_term[i*TERM_W +: TERM_W] : '0);
        end
    endgenerate

    assign cond.ready      = |(hit & unit_ready);
    assign cond.equip_err  = |(hit & unit_equip_err);
    assign cond.term_lines = term_or[N];
endmodule
`default_nettype wire
